// file: verilog/imc_pkg.sv
package imc_pkg;
    // Register map of the status path and its control companion.
    localparam logic [15:0] STATUS_ADDR = 16'h0110;
    localparam logic [15:0] CTRL_ADDR   = 16'h0104;
    // Control bit positions.
    localparam int CTRL_CHK_BIT = 30;
    localparam int CTRL_RST_BIT = 29;
    // Status bit positions.
    localparam int ST_GOOD_BIT  = 31;
    localparam int ST_RESP_BIT  = 30;
    localparam int ST_EXEC_BIT  = 29;
    localparam int ST_ERR_HI    = 14;
    localparam int ST_ERR_LO    = 10;
    localparam int ST_LOC_HI    = 6;
    // Error vector order, bit 4 down to bit 0.
    localparam int E_ADDR = 4;
    localparam int E_FMT  = 3;
    localparam int E_CODE = 2;
    localparam int E_CMD  = 1;
    localparam int E_SIZE = 0;
    // Frame layout in byte positions.
    localparam logic [9:0] POS_DA_END = 10'h0006;
    localparam logic [9:0] POS_TAG_HI = 10'h000C;
    localparam logic [9:0] POS_TAG_LO = 10'h000D;
    localparam logic [9:0] POS_FMT_HI = 10'h000E;
    localparam logic [9:0] POS_FMT_LO = 10'h000F;
    localparam logic [9:0] POS_ACC_HI = 10'h0010;
    localparam logic [9:0] POS_ACC_LO = 10'h0011;
    localparam logic [9:0] POS_CMD    = 10'h0012;
    localparam logic [9:0] MAX_LEN    = 10'h0140;
    // Field values.
    localparam logic [15:0] ACC_FORMAT = 16'h9800;
    localparam logic [15:0] ACC_CODE_A = 16'h0001;
    localparam logic [15:0] ACC_CODE_B = 16'h0002;
    localparam logic [7:0]  CMD_END    = 8'h00;
    localparam logic [7:0]  CMD_FIRST  = 8'h01;
    localparam logic [7:0]  CMD_LAST   = 8'h04;

    typedef enum logic [1:0] {
        IMC_IDLE = 2'b00,
        IMC_EXEC = 2'b01,
        IMC_RESP = 2'b11
    } imc_fsm_t;

    typedef struct packed {
        imc_fsm_t    fsm;
        logic        good;
        logic        resp_done;
        logic        exec_done;
        logic [4:0]  err;
        logic [6:0]  loc;
        logic        chk_en;
        logic        mreset;
        logic [31:0] rdata;
        logic        exec_req;
        logic        resp_req;
    } imc_state_t;

    typedef struct packed {
        logic [9:0] cnt;
        logic       busy;
        logic       da_mis;
        logic       tag_mis;
        logic       fmt_mis;
        logic [7:0] acc_hi;
        logic       acc_bad;
        logic       cmd_end;
        logic       cmd_err;
        logic [6:0] loc;
        logic [6:0] idx;
        logic [2:0] sub;
        logic       done;
    } imc_parse_t;
endpackage : imc_pkg

// file: verilog/imc_chk_if.sv
`timescale 1ns/1ps
interface imc_chk_if;
    logic       done;
    logic       tag_ok;
    logic       addr_mis;
    logic       fmt_err;
    logic       code_err;
    logic       cmd_err;
    logic [6:0] cmd_loc;
    logic       oversize;

    modport parser (output done, tag_ok, addr_mis, fmt_err, code_err, cmd_err, cmd_loc, oversize);
    modport status (input done, tag_ok, addr_mis, fmt_err, code_err, cmd_err, cmd_loc, oversize);
endinterface : imc_chk_if

// file: verilog/imc_frame_parser.sv
`timescale 1ns/1ps
module imc_frame_parser (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rx_valid,
    input  wire logic        rx_sof,
    input  wire logic        rx_eof,
    input  wire logic [7:0]  rx_data,
    input  wire logic [47:0] switch_mac,
    input  wire logic [15:0] mgmt_tpid,
    imc_chk_if.parser        chk
);
    imc_pkg::imc_parse_t s_reg;
    imc_pkg::imc_parse_t s_next;

    // Each byte is checked as it passes, so no frame storage is needed.
    always_comb begin
        logic [9:0] pos;
        logic [7:0] mac_byte;
        pos = s_reg.cnt;
        mac_byte = 8'(switch_mac >> (6'h28 - 6'(pos[2:0]) * 6'h08));
        s_next = s_reg;
        s_next.done = 1'b0;
        if (rx_valid && (rx_sof || s_reg.busy)) begin
            if (rx_sof) begin
                s_next = '0;
                s_next.busy = 1'b1;
                pos = '0;
                mac_byte = switch_mac[47:40];
            end
            if (pos < imc_pkg::POS_DA_END && rx_data != mac_byte) begin
                s_next.da_mis = 1'b1; // [R12]
            end
            if ((pos == imc_pkg::POS_TAG_HI && rx_data != mgmt_tpid[15:8]) ||
                (pos == imc_pkg::POS_TAG_LO && rx_data != mgmt_tpid[7:0])) begin
                s_next.tag_mis = 1'b1;
            end
            if ((pos == imc_pkg::POS_FMT_HI && rx_data != imc_pkg::ACC_FORMAT[15:8]) ||
                (pos == imc_pkg::POS_FMT_LO && rx_data != imc_pkg::ACC_FORMAT[7:0])) begin
                s_next.fmt_mis = 1'b1; // [R6]
            end
            if (pos == imc_pkg::POS_ACC_HI) begin
                s_next.acc_hi = rx_data;
            end
            if (pos == imc_pkg::POS_ACC_LO &&
                {s_next.acc_hi, rx_data} != imc_pkg::ACC_CODE_A &&
                {s_next.acc_hi, rx_data} != imc_pkg::ACC_CODE_B) begin
                s_next.acc_bad = 1'b1; // [R7]
            end
            // Commands sit on an eight-byte stride; a zero code ends the list.
            if (pos >= imc_pkg::POS_CMD && !s_next.cmd_end) begin
                if (s_next.sub == 3'h0) begin
                    if (rx_data == imc_pkg::CMD_END) begin
                        s_next.cmd_end = 1'b1;
                    end else if ((rx_data < imc_pkg::CMD_FIRST || rx_data > imc_pkg::CMD_LAST) &&
                                 !s_next.cmd_err) begin
                        s_next.cmd_err = 1'b1; // [R8]
                        s_next.loc = s_next.idx; // [R11]
                    end
                end
                if (s_next.sub == 3'h7) begin
                    s_next.idx = s_next.idx + 7'h01;
                end
                s_next.sub = s_next.sub + 3'h1;
            end
            // The count saturates well above the size limit.
            if (pos != 10'h3FF) begin
                s_next.cnt = pos + 10'h001;
            end
            if (rx_eof) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Frames too short to carry the header never count as management frames.
    assign chk.done     = s_reg.done;
    assign chk.tag_ok   = !s_reg.tag_mis && s_reg.cnt >= imc_pkg::POS_CMD;
    assign chk.addr_mis = s_reg.da_mis;
    assign chk.fmt_err  = s_reg.fmt_mis;
    assign chk.code_err = s_reg.acc_bad;
    assign chk.cmd_err  = s_reg.cmd_err;
    assign chk.cmd_loc  = s_reg.loc;
    assign chk.oversize = s_reg.cnt > imc_pkg::MAX_LEN; // [R9]
endmodule : imc_frame_parser

// file: verilog/imc_status_checker.sv
`timescale 1ns/1ps
// Functional notes
// [R1] Status bit 31 sets when a valid management packet arrives.
// [R2] Status bit 30 sets once the reply frame has been transmitted.
// [R3] Status bit 29 sets only after all commands of a packet executed.
// [R4] A tag-matching packet clears bits 30, 29 and error bits 14 to 10.
// [R5] Bit 14 flags a destination address mismatch, only while checking is on.
// [R6] Bit 13 flags an access format other than 0x9800.
// [R7] Only access codes 0x0001 and 0x0002 pass; others set bit 12.
// [R8] Bit 11 flags an unrecognised command code.
// [R9] Packets above 320 bytes including padding and checksum set bit 10.
// [R10] No reply frame is sent for an oversized packet.
// [R11] Bits 6:0 give the position of the bad command while bit 11 is set.
// [R12] With control bit 30 set, frames not matching the switch address are dropped.
// [R13] Writing one to control bit 29 restarts the engine and clears itself.
// [R14] Writes to the status register are ignored; it reads zero after reset.
module imc_status_checker (
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    input  wire logic        RX_VALID,
    input  wire logic        RX_SOF,
    input  wire logic        RX_EOF,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic [47:0] SWITCH_MAC,
    input  wire logic [15:0] MGMT_TPID,
    input  wire logic        EXEC_DONE,
    input  wire logic        TX_DONE,
    output logic             EXEC_REQ,
    output logic             RESP_REQ
);
    imc_pkg::imc_state_t st_reg;
    imc_pkg::imc_state_t st_next;
    imc_chk_if           chk ();
    logic                parse_rst;
    logic                accept_evt;
    logic [4:0]          new_err;
    logic [31:0]         status_word;

    // The parser is restarted together with the engine.
    assign parse_rst = SYS_RST || st_reg.mreset; // [R13]

    imc_frame_parser u_parser (
        .clk        (CLOCK),
        .rst        (parse_rst),
        .rx_valid   (RX_VALID),
        .rx_sof     (RX_SOF),
        .rx_eof     (RX_EOF),
        .rx_data    (RX_DATA),
        .switch_mac (SWITCH_MAC),
        .mgmt_tpid  (MGMT_TPID),
        .chk        (chk)
    );

    // Only tag-matching frames seen while idle are taken; others pass by.
    assign accept_evt = chk.done && chk.tag_ok &&
                        st_reg.fsm == imc_pkg::IMC_IDLE && !st_reg.mreset;

    // Errors found in the frame just finished.
    assign new_err[imc_pkg::E_ADDR] = st_reg.chk_en && chk.addr_mis; // [R5]
    assign new_err[imc_pkg::E_FMT]  = chk.fmt_err; // [R6]
    assign new_err[imc_pkg::E_CODE] = chk.code_err; // [R7]
    assign new_err[imc_pkg::E_CMD]  = chk.cmd_err; // [R8]
    assign new_err[imc_pkg::E_SIZE] = chk.oversize; // [R9]

    // Read view of the status register; reserved bits read zero.
    always_comb begin
        status_word = '0;
        status_word[imc_pkg::ST_GOOD_BIT] = st_reg.good;
        status_word[imc_pkg::ST_RESP_BIT] = st_reg.resp_done;
        status_word[imc_pkg::ST_EXEC_BIT] = st_reg.exec_done;
        status_word[imc_pkg::ST_ERR_HI:imc_pkg::ST_ERR_LO] = st_reg.err;
        status_word[imc_pkg::ST_LOC_HI:0] = st_reg.loc;
    end

    // Next-state logic for the engine, the flags and the register port.
    always_comb begin
        st_next = st_reg;
        st_next.mreset = 1'b0; // [R13]
        // Register writes; the status register has no write path.
        if (REG_WR && REG_ADDR == imc_pkg::CTRL_ADDR) begin
            st_next.chk_en = REG_WDATA[imc_pkg::CTRL_CHK_BIT]; // [R12]
            st_next.mreset = REG_WDATA[imc_pkg::CTRL_RST_BIT]; // [R13]
        end
        // Register reads, answered on the next edge.
        if (REG_RD) begin
            if (REG_ADDR == imc_pkg::STATUS_ADDR) begin
                st_next.rdata = status_word;
            end else if (REG_ADDR == imc_pkg::CTRL_ADDR) begin
                st_next.rdata = '0;
                st_next.rdata[imc_pkg::CTRL_CHK_BIT] = st_reg.chk_en;
            end else begin
                st_next.rdata = '0;
            end
        end
        if (st_reg.mreset) begin
            // Restart drops any request in flight; flags are kept.
            st_next.fsm = imc_pkg::IMC_IDLE; // [R13]
            st_next.exec_req = 1'b0;
            st_next.resp_req = 1'b0;
        end else begin
            case (st_reg.fsm)
                imc_pkg::IMC_IDLE: begin
                    if (accept_evt) begin
                        // Clear first, then the new errors land on top.
                        st_next.resp_done = 1'b0; // [R4]
                        st_next.exec_done = 1'b0; // [R4]
                        st_next.err = new_err; // [R4]
                        if (new_err[imc_pkg::E_CMD]) begin
                            st_next.loc = chk.cmd_loc; // [R11]
                        end
                        if (new_err[imc_pkg::E_SIZE]) begin
                            st_next.fsm = imc_pkg::IMC_IDLE; // [R10]
                        end else if (new_err[imc_pkg::E_ADDR]) begin
                            st_next.fsm = imc_pkg::IMC_IDLE; // [R12]
                        end else if (new_err != 5'h00) begin
                            // Faulty request: nothing runs, but a reply still goes out.
                            st_next.fsm = imc_pkg::IMC_RESP;
                            st_next.resp_req = 1'b1;
                        end else begin
                            st_next.good = 1'b1; // [R1]
                            st_next.fsm = imc_pkg::IMC_EXEC;
                            st_next.exec_req = 1'b1;
                        end
                    end
                end
                imc_pkg::IMC_EXEC: begin
                    if (EXEC_DONE) begin
                        st_next.exec_done = 1'b1; // [R3]
                        st_next.exec_req = 1'b0;
                        st_next.fsm = imc_pkg::IMC_RESP;
                        st_next.resp_req = 1'b1;
                    end
                end
                imc_pkg::IMC_RESP: begin
                    if (TX_DONE) begin
                        st_next.resp_done = 1'b1; // [R2]
                        st_next.resp_req = 1'b0;
                        st_next.fsm = imc_pkg::IMC_IDLE;
                    end
                end
                default: begin
                    st_next.fsm = imc_pkg::IMC_IDLE;
                end
            endcase
        end
    end

    // All state in one register; reset brings every flag to zero.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            st_reg <= '0; // [R14]
        end else begin
            st_reg <= st_next;
        end
    end

    assign REG_RDATA = st_reg.rdata;
    assign EXEC_REQ  = st_reg.exec_req;
    assign RESP_REQ  = st_reg.resp_req;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    // A clean packet raises the good flag and starts execution.
    good_packet_a : assert property ( // [R1]
        accept_evt && new_err == 5'h00 |=> st_reg.good && EXEC_REQ
    ) else $error("good flag or execution request missing");

    // The reply flag follows transmission and drops the request.
    resp_done_a : assert property ( // [R2]
        st_reg.fsm == imc_pkg::IMC_RESP && TX_DONE && !st_reg.mreset
        |=> st_reg.resp_done && !RESP_REQ
    ) else $error("reply flag not set after transmit");

    // Execution flag only ever rises after the executor reported done.
    exec_done_a : assert property ( // [R3]
        $rose(st_reg.exec_done) |-> $past(EXEC_DONE) && $past(st_reg.fsm) == imc_pkg::IMC_EXEC
    ) else $error("execution flag rose without completion");

    // A tag-matching packet clears the completion flags.
    tag_clear_a : assert property ( // [R4]
        accept_evt |=> !st_reg.resp_done && !st_reg.exec_done && st_reg.err == $past(new_err)
    ) else $error("flags not cleared by matching packet");

    // Address errors need checking enabled, and such frames get no reply.
    addr_check_a : assert property ( // [R5]
        $rose(st_reg.err[imc_pkg::E_ADDR]) |-> $past(st_reg.chk_en) ##1 !RESP_REQ
    ) else $error("address error without checking enabled");

    // Format, code and command errors follow the parser verdicts.
    field_errors_a : assert property ( // [R6]
        accept_evt |=> st_reg.err[3:1] == $past({chk.fmt_err, chk.code_err, chk.cmd_err})
    ) else $error("field error flags differ from parser result");

    // Oversized packets leave the engine idle with no reply.
    oversize_reply_a : assert property ( // [R10]
        accept_evt && chk.oversize
        |=> st_reg.err[imc_pkg::E_SIZE] && !RESP_REQ ##1 !RESP_REQ
    ) else $error("reply requested for oversized packet");

    // The bad command position is captured with the command error.
    cmd_location_a : assert property ( // [R11]
        $rose(st_reg.err[imc_pkg::E_CMD]) |-> st_reg.loc == $past(chk.cmd_loc)
    ) else $error("command location not captured");

    // The restart bit clears itself and idles the engine; a second restart write right behind re-arms it.
    mgmt_restart_a : assert property ( // [R13]
        REG_WR && REG_ADDR == imc_pkg::CTRL_ADDR && REG_WDATA[imc_pkg::CTRL_RST_BIT]
        ##1 !(REG_WR && REG_ADDR == imc_pkg::CTRL_ADDR && REG_WDATA[imc_pkg::CTRL_RST_BIT])
        |-> st_reg.mreset ##1 !st_reg.mreset && st_reg.fsm == imc_pkg::IMC_IDLE && !EXEC_REQ
    ) else $error("restart bit did not self-clear");

    // Software writes never change the status word.
    status_ro_a : assert property ( // [R14]
        REG_WR && REG_ADDR == imc_pkg::STATUS_ADDR && !chk.done && !EXEC_DONE && !TX_DONE
        |=> $stable(status_word)
    ) else $error("status changed by a software write");

    // Leaving reset shows an all-zero status word and no request.
    status_reset_a : assert property ( // [R14]
        $fell(SYS_RST) |-> status_word == 32'h0000_0000 && !EXEC_REQ && !RESP_REQ
    ) else $error("status not zero after reset");

    // The good flag is only ever cleared by reset.
    good_sticky_a : assert property ( // [R1]
        st_reg.good |=> st_reg.good
    ) else $error("good flag dropped without reset");

    // An unknown access code is recorded and nothing is executed.
    access_code_a : assert property ( // [R7]
        accept_evt && chk.code_err
        |=> st_reg.err[imc_pkg::E_CODE] && !EXEC_REQ
    ) else $error("access code error not recorded");

    // An unknown command code is recorded and nothing is executed.
    cmd_error_a : assert property ( // [R8]
        accept_evt && chk.cmd_err
        |=> st_reg.err[imc_pkg::E_CMD] && !EXEC_REQ
    ) else $error("command error not recorded");

    // The oversize flag follows the length verdict of the frame just taken.
    oversize_flag_a : assert property ( // [R9]
        accept_evt |=> st_reg.err[imc_pkg::E_SIZE] == $past(chk.oversize)
    ) else $error("oversize flag differs from frame length");

    // With checking off a wrong address is never reported.
    addr_ignore_a : assert property ( // [R12]
        accept_evt && !st_reg.chk_en |=> !st_reg.err[imc_pkg::E_ADDR]
    ) else $error("address compared while checking is off");

    // A mismatched frame with checking on starts neither execution nor a reply.
    addr_drop_a : assert property ( // [R12]
        accept_evt && st_reg.chk_en && chk.addr_mis
        |=> !EXEC_REQ && !RESP_REQ
    ) else $error("mismatched frame was not discarded");
endmodule : imc_status_checker

// file: bench/imc_host_model.sv
`timescale 1ns/1ps
// Remote management host plus the executor and transmit path that answer the engine's requests.
module imc_host_model (
    input  wire logic        clk,
    input  wire logic [47:0] switch_mac,
    input  wire logic        exec_req,
    input  wire logic        resp_req,
    output logic             rx_valid,
    output logic             rx_sof,
    output logic             rx_eof,
    output logic [7:0]       rx_data,
    output logic             exec_done,
    output logic             tx_done
);
    int ecnt        = 0;
    int tcnt        = 0;
    int wait_cycles = 2;

    // Everything starts idle so the device sees no stray byte after reset.
    initial begin
        rx_valid  = 1'b0;
        rx_sof    = 1'b0;
        rx_eof    = 1'b0;
        rx_data   = 8'h00;
        exec_done = 1'b0;
        tx_done   = 1'b0;
    end

    // Sends one frame byte by byte; the length covers padding and checksum, so long values make oversize frames.
    task automatic send_frame(input logic [15:0] tag, input logic [15:0] fmt, input logic [15:0] acc,
                              input logic [7:0] c0, input logic [7:0] c1, input int len, input logic da_bad);
        logic [151:0] hdr;
        logic [7:0]   b;
        hdr = {switch_mac ^ {da_bad, 47'h0}, 48'h0200_0000_0001, tag, fmt, acc, c0};
        for (int i = 0; i < len; i++) begin
            b = (i < 19) ? hdr[151 - 8 * i -: 8] : ((i == 26) ? c1 : 8'h00);
            @(negedge clk);
            rx_valid = 1'b1;
            rx_sof   = (i == 0);
            rx_eof   = (i == len - 1);
            rx_data  = b;
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_sof   = 1'b0;
        rx_eof   = 1'b0;
        rx_data  = ~rx_data; // A released line must not keep showing the last byte.
    endtask : send_frame

    // One-cycle completion pulses, execution after a settable wait and transmit after a fixed count of 2; a dropped request cancels the pending pulse.
    always @(negedge clk) begin
        exec_done <= exec_req && ecnt == wait_cycles;
        tx_done   <= resp_req && tcnt == 2;
        ecnt      <= exec_req ? ecnt + 1 : 0;
        tcnt      <= resp_req ? tcnt + 1 : 0;
    end
endmodule : imc_host_model

// file: bench/inband_mgmt_status_checker_test.sv
`timescale 1ns/1ps
module inband_mgmt_status_checker_test;
    localparam logic [47:0] MAC  = 48'h0210_3456_789A;
    localparam logic [15:0] TPID = 16'h40FE;
    localparam logic [15:0] FMT  = imc_pkg::ACC_FORMAT;
    logic        clock     = 1'b0;
    logic        sys_rst   = 1'b1;
    logic [15:0] reg_addr  = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic        rx_valid;
    logic        rx_sof;
    logic        rx_eof;
    logic [7:0]  rx_data;
    logic        exec_done;
    logic        tx_done;
    logic        exec_req;
    logic        resp_req;
    logic [31:0] rd;
    int          num_errors = 0;
    int          n_tests    = 0;

    // Free-running 25 MHz clock.
    always #20 clock = ~clock;

    imc_status_checker u_imc_status_checker (
        .CLOCK(clock), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .RX_VALID(rx_valid), .RX_SOF(rx_sof),
        .RX_EOF(rx_eof), .RX_DATA(rx_data), .SWITCH_MAC(MAC), .MGMT_TPID(TPID),
        .EXEC_DONE(exec_done), .TX_DONE(tx_done), .EXEC_REQ(exec_req), .RESP_REQ(resp_req)
    );

    imc_host_model u_imc_host_model (
        .clk(clock), .switch_mac(MAC), .exec_req(exec_req), .resp_req(resp_req), .rx_valid(rx_valid),
        .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data), .exec_done(exec_done), .tx_done(tx_done)
    );

    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task automatic check1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check1

    // Expected status word built from the field positions.
    function automatic logic [31:0] st(input logic g, input logic r, input logic x, input logic [4:0] e,
                                       input logic [6:0] l);
        st = 32'h0000_0000;
        st[imc_pkg::ST_GOOD_BIT] = g;
        st[imc_pkg::ST_RESP_BIT] = r;
        st[imc_pkg::ST_EXEC_BIT] = x;
        st[imc_pkg::ST_ERR_HI:imc_pkg::ST_ERR_LO] = e;
        st[imc_pkg::ST_LOC_HI:0] = l;
    endfunction : st

    task automatic reg_write(input logic [15:0] addr, input logic [31:0] data);
        @(negedge clock);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
    endtask : reg_write

    // Waits a second cycle before sampling; the read data holds until the next read strobe.
    task automatic reg_read(input logic [15:0] addr, output logic [31:0] data);
        @(negedge clock);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd   = 1'b0;
        @(negedge clock);
        data     = reg_rdata;
    endtask : reg_read

    // Bounded wait for both requests to drop; a hang shows up as a request still high.
    task automatic wait_idle();
        repeat (3) @(negedge clock);
        for (int i = 0; i < 200 && (exec_req !== 1'b0 || resp_req !== 1'b0); i++) @(negedge clock);
        check1(exec_req | resp_req, 1'b0);
    endtask : wait_idle

    task automatic frame(input logic [15:0] fmt, input logic [15:0] acc, input logic [7:0] c0,
                         input logic [7:0] c1, input int len, input logic da_bad, input logic [31:0] exp);
        u_imc_host_model.send_frame(TPID, fmt, acc, c0, c1, len, da_bad);
        wait_idle();
        reg_read(imc_pkg::STATUS_ADDR, rd);
        check32(rd, exp);
    endtask : frame

    task automatic print_verdict();
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // Watchdog well beyond the few thousand cycles the sequence needs.
    initial begin
        #(40 * 20000);
        num_errors++;
        print_verdict();
    end

    // Main sequence: register access, every error kind, boundaries, address checking and restart.
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        reg_read(imc_pkg::STATUS_ADDR, rd);
        check32(rd, 32'h0000_0000);
        reg_write(imc_pkg::STATUS_ADDR, 32'hFFFF_FFFF);
        reg_read(imc_pkg::STATUS_ADDR, rd);
        check32(rd, 32'h0000_0000);
        reg_read(16'h0200, rd);
        check32(rd, 32'h0000_0000);
        frame(16'h9801, 16'h0001, 8'h01, 8'h00, 64, 1'b0, st(0, 1, 0, 5'b01000, 7'd0));
        frame(FMT, 16'h0001, 8'h01, 8'h02, 64, 1'b0, st(1, 1, 1, 5'b00000, 7'd0));
        u_imc_host_model.wait_cycles = 30;
        u_imc_host_model.send_frame(TPID, FMT, 16'h0002, 8'h03, 8'h00, 64, 1'b0);
        repeat (6) @(negedge clock);
        check1(exec_req, 1'b1);
        reg_read(imc_pkg::STATUS_ADDR, rd);
        check32(rd, st(1, 0, 0, 5'b00000, 7'd0));
        wait_idle();
        u_imc_host_model.wait_cycles = 2;
        for (int c = 0; c < 4; c++) begin
            frame(FMT, 16'(c), 8'h04, 8'h00, 64, 1'b0, (c == 1 || c == 2) ? st(1, 1, 1, 5'b0, 7'd0)
                  : st(1, 1, 0, 5'b00100, 7'd0));
        end
        for (int k = 1; k < 6; k++) begin
            frame(FMT, 16'h0001, 8'h01, 8'(k), 64, 1'b0, (k < 5) ? st(1, 1, 1, 5'b0, 7'd0)
                  : st(1, 1, 0, 5'b00010, 7'd1));
        end
        frame(FMT, 16'h0001, 8'h05, 8'h01, 64, 1'b0, st(1, 1, 0, 5'b00010, 7'd0));
        frame(16'h0800, 16'h0009, 8'h01, 8'h00, 64, 1'b0, st(1, 1, 0, 5'b01100, 7'd0));
        frame(FMT, 16'h0001, 8'h01, 8'h00, 320, 1'b0, st(1, 1, 1, 5'b00000, 7'd0));
        frame(16'h9801, 16'h0001, 8'h01, 8'h00, 321, 1'b0, st(1, 0, 0, 5'b01001, 7'd0));
        frame(FMT, 16'h0001, 8'h01, 8'h00, 64, 1'b1, st(1, 1, 1, 5'b00000, 7'd0));
        reg_write(imc_pkg::CTRL_ADDR, 32'h4000_0000);
        reg_read(imc_pkg::CTRL_ADDR, rd);
        check32(rd, 32'h4000_0000);
        frame(FMT, 16'h0001, 8'h01, 8'h00, 64, 1'b1, st(1, 0, 0, 5'b10000, 7'd0));
        u_imc_host_model.send_frame(16'h1234, 16'h9801, 16'h0001, 8'h01, 8'h00, 64, 1'b0);
        wait_idle();
        reg_read(imc_pkg::STATUS_ADDR, rd);
        check32(rd, st(1, 0, 0, 5'b10000, 7'd0));
        frame(FMT, 16'h0001, 8'h01, 8'h00, 64, 1'b0, st(1, 1, 1, 5'b00000, 7'd0));
        u_imc_host_model.wait_cycles = 30;
        u_imc_host_model.send_frame(TPID, FMT, 16'h0001, 8'h02, 8'h00, 64, 1'b0);
        repeat (4) @(negedge clock);
        reg_write(imc_pkg::CTRL_ADDR, 32'h6000_0000);
        repeat (2) @(negedge clock);
        check1(exec_req, 1'b0);
        reg_read(imc_pkg::CTRL_ADDR, rd);
        check32(rd, 32'h4000_0000);
        reg_read(imc_pkg::STATUS_ADDR, rd);
        check32(rd, st(1, 0, 0, 5'b00000, 7'd0));
        u_imc_host_model.wait_cycles = 2;
        frame(FMT, 16'h0001, 8'h01, 8'h00, 64, 1'b0, st(1, 1, 1, 5'b00000, 7'd0));
        print_verdict();
    end
endmodule : inband_mgmt_status_checker_test
